// ### hw/icir_pkg.sv
// Package for the isochronous context interrupt register block.
// Assumes a 32-bit register port with byte offsets as addresses.
package icir_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] ICIR_TX_EVT_SET = 8'h90;
    localparam logic [7:0] ICIR_TX_EVT_CLR = 8'h94;
    localparam logic [7:0] ICIR_TX_MSK_SET = 8'h98;
    localparam logic [7:0] ICIR_TX_MSK_CLR = 8'h9C;
    localparam logic [7:0] ICIR_RX_EVT_SET = 8'hA0;
    localparam logic [7:0] ICIR_RX_EVT_CLR = 8'hA4;
    localparam logic [7:0] ICIR_RX_MSK_SET = 8'hA8;
    localparam logic [7:0] ICIR_RX_MSK_CLR = 8'hAC;
    localparam logic [7:0] ICIR_MAIN_MSK_SET = 8'hB0;
    localparam logic [7:0] ICIR_MAIN_MSK_CLR = 8'hB4;
    // ==========================================================
    // Field positions in the main mask and summary view
    localparam int ICIR_TX_SUM_BIT = 6;
    localparam int ICIR_RX_SUM_BIT = 7;
    localparam int ICIR_GATE_BIT = 31;
    // ==========================================================
    // Reset values
    localparam logic ICIR_RST_BIT = 1'h0;
endpackage : icir_pkg

// ### hw/icir_top.sv
// Per-context isochronous interrupt event and mask registers.
// Assumes synchronous context interrupt inputs and a register master
// that issues one-cycle strobes and never waits.
// Operation
// - Transmit context irq line pulses on last output command with irq enabled.
// - Receive context irq line pulses on any input command with irq enabled.
// - Tx event bit sets on irq rising edge or set-alias write of one.
// - Tx event bit clears only by writing one through the clear alias.
// - Tx clear alias read returns events ANDed with mask.
// - Rx event bit sets on edge or set write; clears by clear write.
// - Rx clear alias read returns events ANDed with mask.
// - Tx event has eight bits; upper bits read zero.
// - Tx event bit n feeds the transmit summary event, main bit 6.
// - Rx event has four bits; upper bits read zero.
// - Rx event bit n feeds the receive summary event, main bit 7.
// - Tx mask reads the same through either alias.
// - Tx mask bit n enables tx event bit n into the summary.
// - Rx mask reads through either alias; bit n enables rx event n.
// - Tx summary interrupts only when main mask bit 6 is set.
// - Rx summary interrupts only when main mask bit 7 is set.
// - No interrupt unless the global gate bit 31 is set.
`timescale 1ns/10ps
module icir_top
    import icir_pkg::*;
#(
    parameter int TX_CTX = 8,
    parameter int RX_CTX = 4
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [TX_CTX-1:0] tx_ctx_irq_i,
    input wire logic [RX_CTX-1:0] rx_ctx_irq_i,
    output logic [31:0] reg_rdata_o,
    output logic tx_summary_event_o,
    output logic rx_summary_event_o,
    output logic irq_o
);
    // ==========================================================
    // Reset release
    logic rst_meta_ff;
    logic rst_sync_ff;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    wire logic rstn = rst_sync_ff;

    // ==========================================================
    // Decode
    wire logic wr_tx_es = reg_wr_i && (reg_addr_i == ICIR_TX_EVT_SET);
    wire logic wr_tx_ec = reg_wr_i && (reg_addr_i == ICIR_TX_EVT_CLR);
    wire logic wr_tx_ms = reg_wr_i && (reg_addr_i == ICIR_TX_MSK_SET);
    wire logic wr_tx_mc = reg_wr_i && (reg_addr_i == ICIR_TX_MSK_CLR);
    wire logic wr_rx_es = reg_wr_i && (reg_addr_i == ICIR_RX_EVT_SET);
    wire logic wr_rx_ec = reg_wr_i && (reg_addr_i == ICIR_RX_EVT_CLR);
    wire logic wr_rx_ms = reg_wr_i && (reg_addr_i == ICIR_RX_MSK_SET);
    wire logic wr_rx_mc = reg_wr_i && (reg_addr_i == ICIR_RX_MSK_CLR);
    wire logic wr_mm_s = reg_wr_i && (reg_addr_i == ICIR_MAIN_MSK_SET);
    wire logic wr_mm_c = reg_wr_i && (reg_addr_i == ICIR_MAIN_MSK_CLR);

    // ==========================================================
    // Edge detection of context interrupt lines
    // Inputs are synchronous, so a single history flop suffices
    logic [TX_CTX-1:0] tx_irq_d_ff;
    logic [RX_CTX-1:0] rx_irq_d_ff;
    always_ff @(posedge mclk_i or negedge rstn) begin
        if (!rstn) begin
            tx_irq_d_ff <= '0;
            rx_irq_d_ff <= '0;
        end else begin
            tx_irq_d_ff <= tx_ctx_irq_i;
            rx_irq_d_ff <= rx_ctx_irq_i;
        end
    end
    wire logic [TX_CTX-1:0] tx_rise = tx_ctx_irq_i & ~tx_irq_d_ff;
    wire logic [RX_CTX-1:0] rx_rise = rx_ctx_irq_i & ~rx_irq_d_ff;

    // ==========================================================
    // Event registers; a set in the same cycle as a clear wins
    logic [TX_CTX-1:0] tx_evt_ff;
    logic [RX_CTX-1:0] rx_evt_ff;
    logic [TX_CTX-1:0] nxt_tx_evt;
    logic [RX_CTX-1:0] nxt_rx_evt;
    wire logic [TX_CTX-1:0] tx_wd = reg_wdata_i[TX_CTX-1:0];
    wire logic [RX_CTX-1:0] rx_wd = reg_wdata_i[RX_CTX-1:0];
    always_comb begin
        nxt_tx_evt = tx_evt_ff;
        if (wr_tx_ec) begin
            nxt_tx_evt = nxt_tx_evt & ~tx_wd;
        end
        nxt_tx_evt = nxt_tx_evt | tx_rise;
        if (wr_tx_es) begin
            nxt_tx_evt = nxt_tx_evt | tx_wd;
        end
    end
    always_comb begin
        nxt_rx_evt = rx_evt_ff;
        if (wr_rx_ec) begin
            nxt_rx_evt = nxt_rx_evt & ~rx_wd;
        end
        nxt_rx_evt = nxt_rx_evt | rx_rise;
        if (wr_rx_es) begin
            nxt_rx_evt = nxt_rx_evt | rx_wd;
        end
    end
    always_ff @(posedge mclk_i or negedge rstn) begin
        if (!rstn) begin
            tx_evt_ff <= '0;
            rx_evt_ff <= '0;
        end else begin
            tx_evt_ff <= nxt_tx_evt;
            rx_evt_ff <= nxt_rx_evt;
        end
    end

    // ==========================================================
    // Mask registers, including the main mask bits this block owns
    logic [TX_CTX-1:0] tx_msk_ff;
    logic [RX_CTX-1:0] rx_msk_ff;
    logic mm_tx_ff;
    logic mm_rx_ff;
    logic mm_gate_ff;
    always_ff @(posedge mclk_i or negedge rstn) begin
        if (!rstn) begin
            tx_msk_ff <= '0;
        end else if (wr_tx_ms) begin
            tx_msk_ff <= tx_msk_ff | tx_wd;
        end else if (wr_tx_mc) begin
            tx_msk_ff <= tx_msk_ff & ~tx_wd;
        end
    end
    always_ff @(posedge mclk_i or negedge rstn) begin
        if (!rstn) begin
            rx_msk_ff <= '0;
        end else if (wr_rx_ms) begin
            rx_msk_ff <= rx_msk_ff | rx_wd;
        end else if (wr_rx_mc) begin
            rx_msk_ff <= rx_msk_ff & ~rx_wd;
        end
    end
    always_ff @(posedge mclk_i or negedge rstn) begin
        if (!rstn) begin
            mm_tx_ff <= ICIR_RST_BIT;
            mm_rx_ff <= ICIR_RST_BIT;
            mm_gate_ff <= ICIR_RST_BIT;
        end else if (wr_mm_s) begin
            mm_tx_ff <= mm_tx_ff | reg_wdata_i[ICIR_TX_SUM_BIT];
            mm_rx_ff <= mm_rx_ff | reg_wdata_i[ICIR_RX_SUM_BIT];
            mm_gate_ff <= mm_gate_ff | reg_wdata_i[ICIR_GATE_BIT];
        end else if (wr_mm_c) begin
            mm_tx_ff <= mm_tx_ff & ~reg_wdata_i[ICIR_TX_SUM_BIT];
            mm_rx_ff <= mm_rx_ff & ~reg_wdata_i[ICIR_RX_SUM_BIT];
            mm_gate_ff <= mm_gate_ff & ~reg_wdata_i[ICIR_GATE_BIT];
        end
    end

    // ==========================================================
    // Summary events and interrupt; registered, so one cycle behind
    wire logic tx_sum = |(tx_evt_ff & tx_msk_ff);
    wire logic rx_sum = |(rx_evt_ff & rx_msk_ff);
    wire logic tx_fire = tx_sum & mm_tx_ff;
    wire logic rx_fire = rx_sum & mm_rx_ff;
    always_ff @(posedge mclk_i or negedge rstn) begin
        if (!rstn) begin
            tx_summary_event_o <= 1'b0;
            rx_summary_event_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            tx_summary_event_o <= tx_sum;
            rx_summary_event_o <= rx_sum;
            irq_o <= mm_gate_ff & (tx_fire | rx_fire);
        end
    end

    // ==========================================================
    // Read data; unmapped offsets read zero
    logic [31:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (!reg_rd_i) begin
            nxt_rdata = 32'h0000_0000;
        end else if (reg_addr_i == ICIR_TX_EVT_SET) begin
            nxt_rdata[TX_CTX-1:0] = tx_evt_ff;
        end else if (reg_addr_i == ICIR_TX_EVT_CLR) begin
            nxt_rdata[TX_CTX-1:0] = tx_evt_ff & tx_msk_ff;
        end else if (reg_addr_i == ICIR_TX_MSK_SET ||
                     reg_addr_i == ICIR_TX_MSK_CLR) begin
            nxt_rdata[TX_CTX-1:0] = tx_msk_ff;
        end else if (reg_addr_i == ICIR_RX_EVT_SET) begin
            nxt_rdata[RX_CTX-1:0] = rx_evt_ff;
        end else if (reg_addr_i == ICIR_RX_EVT_CLR) begin
            nxt_rdata[RX_CTX-1:0] = rx_evt_ff & rx_msk_ff;
        end else if (reg_addr_i == ICIR_RX_MSK_SET ||
                     reg_addr_i == ICIR_RX_MSK_CLR) begin
            nxt_rdata[RX_CTX-1:0] = rx_msk_ff;
        end else if (reg_addr_i == ICIR_MAIN_MSK_SET ||
                     reg_addr_i == ICIR_MAIN_MSK_CLR) begin
            nxt_rdata[ICIR_TX_SUM_BIT] = mm_tx_ff;
            nxt_rdata[ICIR_RX_SUM_BIT] = mm_rx_ff;
            nxt_rdata[ICIR_GATE_BIT] = mm_gate_ff;
        end
    end
    always_ff @(posedge mclk_i or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            reg_rdata_o <= nxt_rdata;
        end
    end

    // ==========================================================
    // Checks
    a_tx_edge_set: assert property (@(posedge mclk_i) disable iff (!rstn)
        (tx_ctx_irq_i[0] && !tx_irq_d_ff[0]) |=> tx_evt_ff[0])
        else $error("tx edge did not set event");
    a_tx_hold: assert property (@(posedge mclk_i) disable iff (!rstn)
        (tx_evt_ff[1] && !(wr_tx_ec && reg_wdata_i[1])) |=> tx_evt_ff[1])
        else $error("tx event cleared without clear write");
    a_tx_clr_rd: assert property (@(posedge mclk_i) disable iff (!rstn)
        (reg_rd_i && reg_addr_i == ICIR_TX_EVT_CLR) |=>
        reg_rdata_o == {24'h000000, $past(tx_evt_ff & tx_msk_ff)})
        else $error("tx clear alias read wrong");
    a_rx_edge_set: assert property (@(posedge mclk_i) disable iff (!rstn)
        (rx_ctx_irq_i[2] && !rx_irq_d_ff[2]) |=> rx_evt_ff[2])
        else $error("rx edge did not set event");
    a_rx_clr_rd: assert property (@(posedge mclk_i) disable iff (!rstn)
        (reg_rd_i && reg_addr_i == ICIR_RX_EVT_CLR) |=>
        reg_rdata_o == {28'h0000000, $past(rx_evt_ff & rx_msk_ff)})
        else $error("rx clear alias read wrong");
    a_rx_upper_zero: assert property (@(posedge mclk_i) disable iff (!rstn)
        (reg_rd_i && reg_addr_i == ICIR_RX_EVT_SET) |=>
        reg_rdata_o[31:RX_CTX] == '0)
        else $error("rx reserved bits not zero");
    a_msk_zero_wr: assert property (@(posedge mclk_i) disable iff (!rstn)
        (wr_tx_ms && reg_wdata_i[TX_CTX-1:0] == '0) |=> $stable(tx_msk_ff))
        else $error("zero write changed mask");
    a_tx_summary: assert property (@(posedge mclk_i) disable iff (!rstn)
        tx_summary_event_o == $past(|(tx_evt_ff & tx_msk_ff)))
        else $error("tx summary mismatch");
    a_irq_gate: assert property (@(posedge mclk_i) disable iff (!rstn)
        irq_o |-> $past(mm_gate_ff) && $past(tx_fire || rx_fire))
        else $error("irq without gate");
    // ==========================================================
    // Further checks; set and clear are probed on separate bits
    a_tx_ctx_rise: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (tx_ctx_irq_i[7] && !tx_irq_d_ff[7]) |=> tx_evt_ff[7])
        else $error("tx context rise lost");
    a_rx_ctx_rise: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (rx_ctx_irq_i[0] && !rx_irq_d_ff[0]) |=> rx_evt_ff[0])
        else $error("rx context rise lost");
    a_tx_set_wr: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (wr_tx_es && reg_wdata_i[5]) |=> tx_evt_ff[5])
        else $error("tx set write lost");
    a_tx_clr_wr: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (wr_tx_ec && reg_wdata_i[2] && !tx_rise[2]) |=> !tx_evt_ff[2])
        else $error("tx clear write lost");
    a_tx_evt_hold: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (tx_evt_ff[6] && !(wr_tx_ec && reg_wdata_i[6])) |=> tx_evt_ff[6])
        else $error("tx event dropped");
    a_rx_set_wr: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (wr_rx_es && reg_wdata_i[1]) |=> rx_evt_ff[1])
        else $error("rx set write lost");
    a_rx_clr_wr: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (wr_rx_ec && reg_wdata_i[2] && !rx_rise[2]) |=> !rx_evt_ff[2])
        else $error("rx clear write lost");
    a_rx_evt_hold: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (rx_evt_ff[3] && !(wr_rx_ec && reg_wdata_i[3])) |=> rx_evt_ff[3])
        else $error("rx event dropped");
    a_tx_upper_zero: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (reg_rd_i && reg_addr_i == ICIR_TX_EVT_SET) |=> reg_rdata_o[31:TX_CTX] == '0)
        else $error("tx reserved bits not zero");
    a_tx_evt_rd: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (reg_rd_i && reg_addr_i == ICIR_TX_EVT_SET) |=> reg_rdata_o[TX_CTX-1:0] == $past(tx_evt_ff))
        else $error("tx event read wrong");
    a_rx_evt_rd: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (reg_rd_i && reg_addr_i == ICIR_RX_EVT_SET) |=> reg_rdata_o[RX_CTX-1:0] == $past(rx_evt_ff))
        else $error("rx event read wrong");
    a_tx_msk_rd: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (reg_rd_i && reg_addr_i == ICIR_TX_MSK_CLR) |=> reg_rdata_o[TX_CTX-1:0] == $past(tx_msk_ff))
        else $error("tx mask read wrong");
    a_rx_msk_rd: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (reg_rd_i && reg_addr_i == ICIR_RX_MSK_CLR) |=> reg_rdata_o[RX_CTX-1:0] == $past(rx_msk_ff))
        else $error("rx mask read wrong");
    a_tx_msk_set: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        wr_tx_ms |=> tx_msk_ff == ($past(tx_msk_ff) | $past(tx_wd)))
        else $error("tx mask set wrong");
    a_tx_msk_clr: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        wr_tx_mc |=> tx_msk_ff == ($past(tx_msk_ff) & ~$past(tx_wd)))
        else $error("tx mask clear wrong");
    a_rx_msk_set: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        wr_rx_ms |=> rx_msk_ff == ($past(rx_msk_ff) | $past(rx_wd)))
        else $error("rx mask set wrong");
    a_rx_msk_clr: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        wr_rx_mc |=> rx_msk_ff == ($past(rx_msk_ff) & ~$past(rx_wd)))
        else $error("rx mask clear wrong");
    a_rx_summary: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        rx_summary_event_o == $past(|(rx_evt_ff & rx_msk_ff)))
        else $error("rx summary mismatch");
    a_tx_sum_src: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        tx_summary_event_o |-> $past(|tx_evt_ff))
        else $error("tx summary without event");
    a_rx_sum_src: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        rx_summary_event_o |-> $past(|rx_evt_ff))
        else $error("rx summary without event");
    a_irq_tx_path: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (irq_o && !$past(rx_fire)) |-> $past(mm_tx_ff))
        else $error("tx irq without enable");
    a_irq_rx_path: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (irq_o && !$past(tx_fire)) |-> $past(mm_rx_ff))
        else $error("rx irq without enable");
    a_tx_zero_set: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (wr_tx_es && tx_wd == '0 && tx_rise == '0) |=> $stable(tx_evt_ff))
        else $error("zero set write changed event");
    a_rx_zero_clr: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (wr_rx_ec && rx_wd == '0 && rx_rise == '0) |=> $stable(rx_evt_ff))
        else $error("zero clear write changed event");
    a_rx_msk_upper: assert property (@(posedge mclk_i)
        disable iff (!rstn)
        (reg_rd_i && reg_addr_i == ICIR_RX_MSK_SET) |=> reg_rdata_o[31:RX_CTX] == '0)
        else $error("rx mask reserved bits set");
endmodule // icir_top

// ### verif/icir_ctx_model.sv
// Behavioural model of the isochronous DMA context engines.
// Assumes the bench calls its tasks; lines idle low outside pulses.
`timescale 1ns/10ps
module icir_ctx_model (
    input wire logic mclk_i,
    output logic [7:0] tx_ctx_irq_o,
    output logic [3:0] rx_ctx_irq_o
);
    initial begin
        tx_ctx_irq_o = 8'h00;
        rx_ctx_irq_o = 4'h0;
    end
    // ==========================================================
    // Command completion
    // Only a last output command with both irq bits set pulses
    task automatic tx_complete(input int ctx, input bit last,
                               input bit [1:0] ibits);
        @(posedge mclk_i);
        if (last && ibits == 2'h3) begin
            tx_ctx_irq_o[ctx] <= 1'h1;
        end
        @(posedge mclk_i);
        tx_ctx_irq_o[ctx] <= 1'h0;
    endtask
    // Any input command counts, not only the last one
    task automatic rx_complete(input int ctx, input bit [1:0] ibits);
        @(posedge mclk_i);
        if (ibits == 2'h3) begin
            rx_ctx_irq_o[ctx] <= 1'h1;
        end
        @(posedge mclk_i);
        rx_ctx_irq_o[ctx] <= 1'h0;
    endtask
endmodule // icir_ctx_model

// ### verif/icir_top_test.sv
// Self-checking bench for the isochronous interrupt register block.
// Assumes one 20 MHz clock and the context model on the irq lines.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %0t: got %h expected %h", $time, g, e); end end
module icir_top_test;
    import icir_pkg::*;
    logic mclk_i = 1'h0;
    logic resetn_i = 1'h0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'h0;
    logic reg_rd_i = 1'h0;
    logic [7:0] tx_irq;
    logic [3:0] rx_irq;
    logic [31:0] reg_rdata_o;
    logic tx_sum, rx_sum, irq;
    int n_fail = 0;
    int compares = 0;
    logic [7:0] addrs [9] = '{8'h90, 8'h94, 8'h98, 8'h9C, 8'hA0,
                             8'hA4, 8'hA8, 8'hAC, 8'h00};
    always #25 mclk_i = ~mclk_i;
    icir_top i_icir_top (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .tx_ctx_irq_i(tx_irq),
        .rx_ctx_irq_i(rx_irq), .reg_rdata_o(reg_rdata_o),
        .tx_summary_event_o(tx_sum), .rx_summary_event_o(rx_sum),
        .irq_o(irq));
    icir_ctx_model i_icir_ctx_model (.mclk_i(mclk_i),
        .tx_ctx_irq_o(tx_irq), .rx_ctx_irq_o(rx_irq));
    // ==========================================================
    // Register access
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'h1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'h0;
    endtask
    // Data stands only in the cycle after the strobe: grab it mid-cycle
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        reg_rd_i <= 1'h1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'h0;
        @(negedge mclk_i);
        `CHK(reg_rdata_o, e)
    endtask
    // Summaries and irq are registered; let them catch up
    task automatic chk_out(input logic t, input logic r, input logic i);
        repeat (3) @(posedge mclk_i);
        @(negedge mclk_i);
        `CHK({tx_sum, rx_sum, irq}, {t, r, i})
    endtask
    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'h1;
        repeat (3) @(posedge mclk_i);
        for (int k = 0; k < 9; k++) begin
            chk_rd(addrs[k], 32'h0);
        end
        wr(ICIR_TX_MSK_SET, 32'hFFFFFFFF);
        wr(ICIR_TX_MSK_CLR, 32'h0000000F);
        wr(ICIR_TX_MSK_SET, 32'h0);
        chk_rd(ICIR_TX_MSK_SET, 32'hF0);
        chk_rd(ICIR_TX_MSK_CLR, 32'hF0);
        i_icir_ctx_model.tx_complete(3, 1'b0, 2'h3);
        i_icir_ctx_model.tx_complete(5, 1'b1, 2'h1);
        chk_rd(ICIR_TX_EVT_SET, 32'h0);
        i_icir_ctx_model.tx_complete(3, 1'b1, 2'h3);
        chk_rd(ICIR_TX_EVT_SET, 32'h08);
        chk_out(1'b0, 1'b0, 1'b0);
        wr(ICIR_TX_EVT_SET, 32'hFFFFFF80);
        wr(ICIR_TX_EVT_CLR, 32'h0);
        chk_rd(ICIR_TX_EVT_SET, 32'h88);
        chk_rd(ICIR_TX_EVT_CLR, 32'h80);
        chk_out(1'b1, 1'b0, 1'b0);
        wr(ICIR_MAIN_MSK_SET, 32'h40);
        chk_out(1'b1, 1'b0, 1'b0);
        wr(ICIR_MAIN_MSK_SET, 32'h80000000);
        chk_out(1'b1, 1'b0, 1'b1);
        wr(ICIR_TX_EVT_CLR, 32'h08);
        chk_rd(ICIR_TX_EVT_SET, 32'h80);
        wr(ICIR_TX_EVT_CLR, 32'h80);
        chk_out(1'b0, 1'b0, 1'b0);
        wr(ICIR_RX_MSK_SET, 32'hFFFFFFF6);
        chk_rd(ICIR_RX_MSK_CLR, 32'h6);
        i_icir_ctx_model.rx_complete(2, 2'h3);
        i_icir_ctx_model.rx_complete(1, 2'h2);
        chk_rd(ICIR_RX_EVT_SET, 32'h4);
        wr(ICIR_RX_EVT_SET, 32'hFFFFFFF1);
        chk_rd(ICIR_RX_EVT_SET, 32'h5);
        chk_rd(ICIR_RX_EVT_CLR, 32'h4);
        chk_out(1'b0, 1'b1, 1'b0);
        wr(ICIR_MAIN_MSK_SET, 32'h80);
        chk_out(1'b0, 1'b1, 1'b1);
        wr(ICIR_RX_EVT_CLR, 32'hF);
        chk_rd(ICIR_RX_EVT_SET, 32'h0);
        chk_out(1'b0, 1'b0, 1'b0);
        conclude();
    end
    // Whole run is under 150 cycles; allow 4000, some thirty times that
    initial begin
        #(4000 * 50);
        n_fail++;
        conclude();
    end
endmodule // icir_top_test
